// ---- rtl/vfc_pkg.sv ----
// Purpose: shared constants for the vector float convert/compare datapath
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   element 1 is the high word (bits 63:32), element 0 the low word
package vfc_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_OPA_HI   = 8'h04;
  localparam logic [7:0] OFF_OPA_LO   = 8'h08;
  localparam logic [7:0] OFF_OPB_HI   = 8'h0C;
  localparam logic [7:0] OFF_OPB_LO   = 8'h10;
  localparam logic [7:0] OFF_RES_HI   = 8'h14;
  localparam logic [7:0] OFF_RES_LO   = 8'h18;
  localparam logic [7:0] OFF_COND     = 8'h1C;
  localparam logic [7:0] OFF_FPSC     = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  // ----------------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OP_W    = 4;
  localparam int CMD_FLD_LSB = 4;
  localparam int CMD_FLD_W   = 3;
  localparam int FS_INV_L    = 0;
  localparam int FS_INV_H    = 1;
  localparam int FS_G_L      = 2;
  localparam int FS_G_H      = 3;
  localparam int FS_X_L      = 4;
  localparam int FS_X_H      = 5;
  localparam int FS_INV_EN   = 8;
  localparam int FS_RM_LSB   = 9;
  localparam int IRQ_W       = 2;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_EXC     = 1;
  localparam int CR_FW       = 4;
  localparam int CR_MSB      = 31;
  // ----------------------------------------------------------------------
  // operations, rounding, states
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_CFH   = 4'h0;
  localparam logic [3:0] OP_CFSF  = 4'h1;
  localparam logic [3:0] OP_CFSI  = 4'h2;
  localparam logic [3:0] OP_CFUF  = 4'h3;
  localparam logic [3:0] OP_CFUI  = 4'h4;
  localparam logic [3:0] OP_CMPEQ = 4'h5;
  localparam logic [3:0] OP_CMPGT = 4'h6;
  localparam logic [3:0] OP_CMPLT = 4'h7;
  localparam logic [1:0] RM_NEAR  = 2'h0;
  localparam logic [1:0] RM_ZERO  = 2'h1;
  localparam logic [1:0] RM_POS   = 2'h2;
  localparam logic [1:0] RM_NEG   = 2'h3;
  typedef enum logic [0:0] {VFC_IDLE = 1'b0, VFC_EXEC = 1'b1} vfc_state_t;
  // ----------------------------------------------------------------------
  // number formats
  // ----------------------------------------------------------------------
  localparam logic [4:0]  H_EXP_MAX  = 5'h1F;
  localparam logic [7:0]  SP_EXP_MAX = 8'hFF;
  localparam logic [7:0]  H_TO_S_ADJ = 8'h70;
  localparam logic [30:0] SP_MAX_MAG = 31'h7F7FFFFF;
  localparam logic [7:0]  BASE_INT   = 8'h7F;
  localparam logic [7:0]  BASE_SF    = 8'h60;
  localparam logic [7:0]  BASE_UF    = 8'h5F;
  localparam logic [4:0]  TOP_BIT    = 5'h1F;
  localparam logic [31:0] KEY_MID    = 32'h80000000;
endpackage : vfc_pkg

// ---- rtl/vfc_top.sv ----
// Purpose: paired single-precision convert and compare unit behind APB
// Assumes: ref_clk 20 MHz, sys_rst asynchronous active high
// Notes:   a command write runs in one cycle; results commit one edge later
`timescale 1ns/1ps
module vfc_top (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [vfc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic      [31:0]                 prdata,
  output logic                             pslverr,
  output logic                             irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                         pready;
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic                         irq;
    vfc_pkg::vfc_state_t          st;
    logic [3:0]                   op;
    logic [2:0]                   fld;
    logic [31:0]                  opa_h;
    logic [31:0]                  opa_l;
    logic [31:0]                  opb_h;
    logic [31:0]                  opb_l;
    logic [31:0]                  res_h;
    logic [31:0]                  res_l;
    logic [31:0]                  cond;
    logic [1:0]                   inv;
    logic [1:0]                   grd;
    logic [1:0]                   stk;
    logic                         inv_en;
    logic [1:0]                   rm;
    logic [vfc_pkg::IRQ_W-1:0]    irq_stat;
    logic [vfc_pkg::IRQ_W-1:0]    irq_mask;
  } vfc_regs_t;

  vfc_regs_t q_reg;
  vfc_regs_t q_next;

  // ----------------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------------
  // returns {guard, sticky, single}; exponent = base + msb position
  function automatic logic [33:0] to_single(input logic sgn, input logic [31:0] mag,
                                            input logic [7:0] base, input logic [1:0] rm);
    logic [4:0]  p;
    logic [31:0] n;
    logic [24:0] m;
    logic        g;
    logic        x;
    logic        up;
    logic [7:0]  e;
    p = '0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        p = i[4:0];
      end
    end
    n = mag << (vfc_pkg::TOP_BIT - p);
    g = n[7];
    x = |n[6:0];
    unique case (rm)
      vfc_pkg::RM_NEAR: up = g & (x | n[8]);
      vfc_pkg::RM_ZERO: up = 1'b0;
      vfc_pkg::RM_POS:  up = ~sgn & (g | x);
      vfc_pkg::RM_NEG:  up = sgn & (g | x);
    endcase
    m = {1'b0, n[31:8]} + {24'h000000, up};
    // a mantissa carry leaves the fraction all zero, so only the exponent moves
    e = base + {3'h0, p} + {7'h00, m[24]};
    if (mag == '0) begin
      to_single = '0;
    end else begin
      to_single = {g, x, sgn, e, m[22:0]};
    end
  endfunction : to_single

  // orders sign-magnitude words so that +0 and -0 get the same key
  function automatic logic [31:0] cmp_key(input logic [31:0] v);
    if (v[31]) begin
      cmp_key = vfc_pkg::KEY_MID - {1'b0, v[30:0]};
    end else begin
      cmp_key = vfc_pkg::KEY_MID + {1'b0, v[30:0]};
    end
  endfunction : cmp_key

  // ----------------------------------------------------------------------
  // per-element datapath
  // ----------------------------------------------------------------------
  logic [31:0] el_res [2];
  logic [1:0]  el_g;
  logic [1:0]  el_x;
  logic [1:0]  bad_h;
  logic [1:0]  bad_c;
  logic [1:0]  c_eq;
  logic [1:0]  c_gt;
  logic [1:0]  c_lt;

  for (genvar e = 0; e < 2; e++) begin : g_el
    logic [31:0] a;
    logic [31:0] b;
    logic [4:0]  he;
    logic [9:0]  hf;
    logic [33:0] cv;
    logic        neg;
    logic [31:0] mag;
    logic [31:0] ka;
    logic [31:0] kb;
    assign a   = (e == 1) ? q_reg.opa_h : q_reg.opa_l;
    assign b   = (e == 1) ? q_reg.opb_h : q_reg.opb_l;
    assign he  = b[14:10];
    assign hf  = b[9:0];
    assign neg = (q_reg.op == vfc_pkg::OP_CFSF || q_reg.op == vfc_pkg::OP_CFSI) && b[31];
    assign mag = neg ? (32'h00000000 - b) : b;

    always_comb begin
      unique case (q_reg.op)
        vfc_pkg::OP_CFSF: cv = to_single(neg, mag, vfc_pkg::BASE_SF, q_reg.rm);
        vfc_pkg::OP_CFSI: cv = to_single(neg, mag, vfc_pkg::BASE_INT, q_reg.rm);
        vfc_pkg::OP_CFUF: cv = to_single(1'b0, b, vfc_pkg::BASE_UF, q_reg.rm);
        default:          cv = to_single(1'b0, b, vfc_pkg::BASE_INT, q_reg.rm);
      endcase
    end

    // half input: exponent all ones is inf/NaN, zero exponent with fraction is denormal
    assign bad_h[e] = (he == vfc_pkg::H_EXP_MAX) || (he == '0 && hf != '0);
    assign bad_c[e] = (a[30:23] == vfc_pkg::SP_EXP_MAX) || (a[30:23] == '0 && a[22:0] != '0) ||
                      (b[30:23] == vfc_pkg::SP_EXP_MAX) || (b[30:23] == '0 && b[22:0] != '0);

    always_comb begin
      if (q_reg.op == vfc_pkg::OP_CFH) begin
        // exact widening: no rounding step exists on this path
        if (he == vfc_pkg::H_EXP_MAX) begin
          el_res[e] = {b[15], vfc_pkg::SP_MAX_MAG};
        end else if (he == '0) begin
          el_res[e] = {b[15], 31'h00000000};
        end else begin
          el_res[e] = {b[15], {3'h0, he} + vfc_pkg::H_TO_S_ADJ, hf, 13'h0000};
        end
        el_g[e] = 1'b0;
        el_x[e] = 1'b0;
      end else begin
        el_res[e] = cv[31:0];
        el_g[e]   = cv[33];
        el_x[e]   = cv[32];
      end
    end

    // fields used as they stand, so inf/NaN/denorm order like normal numbers
    assign ka      = cmp_key(a);
    assign kb      = cmp_key(b);
    assign c_eq[e] = (ka == kb);
    assign c_gt[e] = (ka > kb);
    assign c_lt[e] = (ka < kb);
  end

  // ----------------------------------------------------------------------
  // register read and decode
  // ----------------------------------------------------------------------
  logic [31:0] rdata;
  logic        hit;
  logic [31:0] fpsc_word;
  logic [3:0]  wr_op;
  logic        cmd_bad;

  always_comb begin
    fpsc_word = '0;
    fpsc_word[vfc_pkg::FS_INV_L]              = q_reg.inv[0];
    fpsc_word[vfc_pkg::FS_INV_H]              = q_reg.inv[1];
    fpsc_word[vfc_pkg::FS_G_L]                = q_reg.grd[0];
    fpsc_word[vfc_pkg::FS_G_H]                = q_reg.grd[1];
    fpsc_word[vfc_pkg::FS_X_L]                = q_reg.stk[0];
    fpsc_word[vfc_pkg::FS_X_H]                = q_reg.stk[1];
    fpsc_word[vfc_pkg::FS_INV_EN]             = q_reg.inv_en;
    fpsc_word[vfc_pkg::FS_RM_LSB +: 2]        = q_reg.rm;
  end

  assign wr_op   = pwdata[vfc_pkg::CMD_OP_LSB +: vfc_pkg::CMD_OP_W];
  // unknown opcodes are refused with pslverr rather than silently dropped
  assign cmd_bad = pwrite && paddr == vfc_pkg::OFF_CMD && wr_op > vfc_pkg::OP_CMPLT;

  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    unique case (paddr)
      vfc_pkg::OFF_CMD:      rdata = {24'h000000, q_reg.fld, q_reg.op, 1'b0} >> 1 |
                                     {31'h00000000, q_reg.st == vfc_pkg::VFC_EXEC} << 31;
      vfc_pkg::OFF_OPA_HI:   rdata = q_reg.opa_h;
      vfc_pkg::OFF_OPA_LO:   rdata = q_reg.opa_l;
      vfc_pkg::OFF_OPB_HI:   rdata = q_reg.opb_h;
      vfc_pkg::OFF_OPB_LO:   rdata = q_reg.opb_l;
      vfc_pkg::OFF_RES_HI:   rdata = q_reg.res_h;
      vfc_pkg::OFF_RES_LO:   rdata = q_reg.res_l;
      vfc_pkg::OFF_COND:     rdata = q_reg.cond;
      vfc_pkg::OFF_FPSC:     rdata = fpsc_word;
      vfc_pkg::OFF_IRQ_STAT: rdata = {30'h00000000, q_reg.irq_stat};
      vfc_pkg::OFF_IRQ_MASK: rdata = {30'h00000000, q_reg.irq_mask};
      default:               hit   = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic                      wr;
  logic                      exc;
  logic [vfc_pkg::IRQ_W-1:0] ev;
  logic [vfc_pkg::IRQ_W-1:0] w1c;
  logic [3:0]                fval;
  logic                      is_cmp;

  assign wr     = psel && penable && q_reg.pready && pwrite && !q_reg.pslverr;
  assign is_cmp = q_reg.op >= vfc_pkg::OP_CMPEQ;
  assign exc    = q_reg.st == vfc_pkg::VFC_EXEC && q_reg.inv_en &&
                  (is_cmp ? |bad_c : (q_reg.op == vfc_pkg::OP_CFH && |bad_h));

  always_comb begin
    unique case (q_reg.op)
      vfc_pkg::OP_CMPEQ: fval = {c_eq[1], c_eq[0], c_eq[1] | c_eq[0], c_eq[1] & c_eq[0]};
      vfc_pkg::OP_CMPGT: fval = {c_gt[1], c_gt[0], c_gt[1] | c_gt[0], c_gt[1] & c_gt[0]};
      default:           fval = {c_lt[1], c_lt[0], c_lt[1] | c_lt[0], c_lt[1] & c_lt[0]};
    endcase
  end

  always_comb begin
    q_next         = q_reg;
    q_next.pready  = 1'b0;
    q_next.pslverr = 1'b0;
    ev             = '0;
    w1c            = '0;
    if (psel && !penable) begin
      q_next.pready  = 1'b1;
      q_next.prdata  = pwrite ? 32'h00000000 : rdata;
      q_next.pslverr = !hit || cmd_bad;
    end
    if (wr) begin
      unique case (paddr)
        vfc_pkg::OFF_CMD: begin
          q_next.op  = wr_op;
          q_next.fld = pwdata[vfc_pkg::CMD_FLD_LSB +: vfc_pkg::CMD_FLD_W];
          q_next.st  = vfc_pkg::VFC_EXEC;
        end
        vfc_pkg::OFF_OPA_HI:   q_next.opa_h = pwdata;
        vfc_pkg::OFF_OPA_LO:   q_next.opa_l = pwdata;
        vfc_pkg::OFF_OPB_HI:   q_next.opb_h = pwdata;
        vfc_pkg::OFF_OPB_LO:   q_next.opb_l = pwdata;
        vfc_pkg::OFF_COND:     q_next.cond  = pwdata;
        vfc_pkg::OFF_FPSC: begin
          q_next.inv    = {pwdata[vfc_pkg::FS_INV_H], pwdata[vfc_pkg::FS_INV_L]};
          q_next.grd    = {pwdata[vfc_pkg::FS_G_H], pwdata[vfc_pkg::FS_G_L]};
          q_next.stk    = {pwdata[vfc_pkg::FS_X_H], pwdata[vfc_pkg::FS_X_L]};
          q_next.inv_en = pwdata[vfc_pkg::FS_INV_EN];
          q_next.rm     = pwdata[vfc_pkg::FS_RM_LSB +: 2];
        end
        vfc_pkg::OFF_IRQ_STAT: w1c = pwdata[vfc_pkg::IRQ_W-1:0];
        vfc_pkg::OFF_IRQ_MASK: q_next.irq_mask = pwdata[vfc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (q_reg.st == vfc_pkg::VFC_EXEC) begin
      q_next.st     = vfc_pkg::VFC_IDLE;
      ev[vfc_pkg::IRQ_DONE] = 1'b1;
      ev[vfc_pkg::IRQ_EXC]  = exc;
      if (is_cmp) begin
        q_next.inv = bad_c;
        q_next.grd = q_reg.grd & ~bad_c;
        q_next.stk = q_reg.stk & ~bad_c;
        if (!exc) begin
          q_next.cond[(vfc_pkg::CR_MSB - vfc_pkg::CR_FW * int'(q_reg.fld)) -: vfc_pkg::CR_FW] = fval;
        end
      end else if (q_reg.op == vfc_pkg::OP_CFH) begin
        q_next.inv = bad_h;
        q_next.grd = '0;
        q_next.stk = '0;
        if (!exc) begin
          q_next.res_h = el_res[1];
          q_next.res_l = el_res[0];
        end
      end else begin
        q_next.inv   = '0;
        q_next.grd   = el_g;
        q_next.stk   = el_x;
        q_next.res_h = el_res[1];
        q_next.res_l = el_res[0];
      end
    end
    // an event in the clearing cycle survives the clear
    q_next.irq_stat = (q_reg.irq_stat & ~w1c) | ev;
    q_next.irq      = |(q_next.irq_stat & q_next.irq_mask);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign pready  = q_reg.pready;
  assign prdata  = q_reg.prdata;
  assign pslverr = q_reg.pslverr;
  assign irq     = q_reg.irq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic run;
  logic [3:0] cur_field;
  assign run       = q_reg.st == vfc_pkg::VFC_EXEC;
  assign cur_field = q_reg.cond[(vfc_pkg::CR_MSB - vfc_pkg::CR_FW * int'(q_reg.fld)) -: vfc_pkg::CR_FW];

  a_half_exact: assert property (run && !exc && q_reg.op == vfc_pkg::OP_CFH && q_reg.opb_l[14:10] == 5'h0F
    |=> q_reg.res_l == {$past(q_reg.opb_l[15]), 8'h7F, $past(q_reg.opb_l[9:0]), 13'h0000})
    else $error("half to single result wrong");
  a_half_norm: assert property (run && !exc && q_reg.op == vfc_pkg::OP_CFH
    |=> (q_reg.res_h[12:0] == 13'h0000 || $past(q_reg.opb_h[14:10]) == vfc_pkg::H_EXP_MAX) &&
        (q_reg.res_l[12:0] == 13'h0000 || $past(q_reg.opb_l[14:10]) == vfc_pkg::H_EXP_MAX))
    else $error("half conversion rounded");
  a_half_flags: assert property (run && q_reg.op == vfc_pkg::OP_CFH
    |=> q_reg.grd == 2'h0 && q_reg.stk == 2'h0 && q_reg.inv == $past(bad_h))
    else $error("half conversion flags wrong");
  a_half_hold: assert property (run && exc && q_reg.op == vfc_pkg::OP_CFH
    |=> $stable(q_reg.res_h) && $stable(q_reg.res_l) && q_reg.irq_stat[vfc_pkg::IRQ_EXC])
    else $error("destination changed on exception");
  a_exc_only_inv: assert property (run && exc && q_reg.op == vfc_pkg::OP_CFH
    |=> $stable(q_reg.cond) && $stable(q_reg.rm) && $stable(q_reg.inv_en))
    else $error("exception touched other state");
  a_sfrac_neg: assert property (run && q_reg.op == vfc_pkg::OP_CFSF && q_reg.opb_l == 32'h80000000
    |=> q_reg.res_l == 32'hBF800000) else $error("signed fraction -1 wrong");
  a_sint_one: assert property (run && q_reg.op == vfc_pkg::OP_CFSI && q_reg.opb_h == 32'h00000001
    |=> q_reg.res_h == 32'h3F800000) else $error("signed integer 1 wrong");
  a_ufrac_half: assert property (run && q_reg.op == vfc_pkg::OP_CFUF && q_reg.opb_l == 32'h80000000
    |=> q_reg.res_l == 32'h3F000000) else $error("unsigned fraction half wrong");
  a_uint_trunc: assert property (run && q_reg.op == vfc_pkg::OP_CFUI && q_reg.opb_l == 32'hFFFFFFFF
    && q_reg.rm == vfc_pkg::RM_ZERO |=> q_reg.res_l == 32'h4F7FFFFF) else $error("unsigned truncation wrong");
  a_eq_zeros: assert property (run && !exc && q_reg.op == vfc_pkg::OP_CMPEQ && q_reg.opa_h[30:0] == 31'h0
    && q_reg.opb_h[30:0] == 31'h0 |=> cur_field[3]) else $error("signed zeros unequal");
  a_gt_excl: assert property (run && !exc && q_reg.op == vfc_pkg::OP_CMPGT && q_reg.opa_l == q_reg.opb_l
    |=> !cur_field[2]) else $error("equal operands compared greater");
  a_field_form: assert property (run && !exc && is_cmp
    |=> cur_field[1] == (cur_field[3] | cur_field[2]) && cur_field[0] == (cur_field[3] & cur_field[2]))
    else $error("condition field layout wrong");
  a_cmp_hold: assert property (run && exc && is_cmp |=> $stable(q_reg.cond))
    else $error("condition register changed on exception");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_half_exc: cover property (run && exc && q_reg.op == vfc_pkg::OP_CFH);
  c_lt_done:  cover property (run && !exc && q_reg.op == vfc_pkg::OP_CMPLT);
  c_sint_run: cover property (run && q_reg.op == vfc_pkg::OP_CFSI);
  c_irq_up:   cover property ($rose(irq));
endmodule : vfc_top

// ---- tb/vfc_apb_master.sv ----
// Purpose: APB master standing in for the core pipeline
// Assumes: pready sampled at the rising edge
// Notes:   released write data is inverted, never held stale
`timescale 1ns/1ps
module vfc_apb_master (
  input  wire logic                       ref_clk,
  input  wire logic                       pready,
  input  wire logic [31:0]                prdata,
  input  wire logic                       pslverr,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic [vfc_pkg::ADDR_W-1:0]      paddr,
  output logic [31:0]                     pwdata
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d;
  endtask : xfer
endmodule : vfc_apb_master

// ---- tb/vector_sp_float_convert_compare_bench.sv ----
// Purpose: self-checking bench for vfc_top
// Assumes: reset held 6 cycles, xorshift seed 8
// Notes:   random conversions get exact inputs; rounding has its own corner
`timescale 1ns/1ps
module vector_sp_float_convert_compare_bench;
  logic        ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, x = 32'h8, a0, a1, b0, b1, c, ex, res_lo;
  int          failures = 0;
  int          samples_checked = 0;
  always #25 ref_clk = ~ref_clk;
  vfc_top i_vfc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
  vfc_apb_master i_vfc_apb_master (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  function automatic logic [31:0] h2s(input logic [15:0] h);
    if (h[14:10] == 5'h0) return {h[15], 31'h0};
    if (h[14:10] == 5'h1F) return {h[15], 31'h7F7FFFFF};
    return {h[15], {3'h0, h[14:10]} + 8'h70, h[9:0], 13'h0};
  endfunction : h2s
  function automatic logic hbad(input logic [15:0] h);
    return h[14:10] == 5'h1F || (h[14:10] == 5'h0 && h[9:0] != 10'h0);
  endfunction : hbad
  function automatic logic bad(input logic [31:0] f);
    return f[30:23] == 8'hFF || (f[30:23] == 8'h0 && f[22:0] != 23'h0);
  endfunction : bad
  function automatic logic [31:0] mk(input logic [31:0] r, input logic sg);
    logic [31:0] u;
    u = {8'h0, r[23:0]} << r[26:24];
    return (sg && r[31]) ? -u : u;
  endfunction : mk
  function automatic logic [31:0] i2f(input logic [31:0] v, input logic sg, input int sc);
    logic [31:0] m;
    int          p;
    m = (sg && v[31]) ? -v : v;
    if (m == 32'h0) return 32'h0;
    p = 31;
    while (!m[p]) p--;
    m = (p > 23) ? m >> (p - 23) : m << (23 - p);
    return {sg & v[31], 8'(127 + p - sc), m[22:0]};
  endfunction : i2f
  // sign-magnitude order key; both zeros land on the midpoint
  function automatic logic [31:0] key(input logic [31:0] f);
    return f[31] ? 32'h80000000 - {1'h0, f[30:0]} : 32'h80000000 + {1'h0, f[30:0]};
  endfunction : key
  function automatic logic cmpb(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
    if (op == vfc_pkg::OP_CMPEQ) return key(a) == key(b);
    if (op == vfc_pkg::OP_CMPGT) return key(a) > key(b);
    return key(a) < key(b);
  endfunction : cmpb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_vfc_apb_master.xfer(1'h1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_vfc_apb_master.xfer(1'h0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd
  task automatic ops(input logic [31:0] ah, input logic [31:0] al, input logic [31:0] bh, input logic [31:0] bl);
    wr(vfc_pkg::OFF_OPA_HI, ah);
    wr(vfc_pkg::OFF_OPA_LO, al);
    wr(vfc_pkg::OFF_OPB_HI, bh);
    wr(vfc_pkg::OFF_OPB_LO, bl);
  endtask : ops
  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
  initial begin
    logic [3:0]  op;
    logic [2:0]  k;
    logic        sg, ch, cl;
    logic [31:0] rm;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(vfc_pkg::OFF_FPSC, 32'h0);
    rd(8'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(vfc_pkg::OFF_CMD, 32'hF);
    chk({31'h0, e}, 32'h1);
    wr(vfc_pkg::OFF_IRQ_MASK, 32'h2);
    for (int i = 0; i < 40; i++) begin
      rm = rnd() & 32'h600;
      a0 = (i == 0) ? 32'h7C00 : rnd();
      a1 = rnd();
      wr(vfc_pkg::OFF_FPSC, rm);
      ops(32'h0, 32'h0, a1, a0);
      wr(vfc_pkg::OFF_CMD, {28'h0, vfc_pkg::OP_CFH});
      rd(vfc_pkg::OFF_RES_HI, h2s(a1[15:0]));
      rd(vfc_pkg::OFF_RES_LO, h2s(a0[15:0]));
      rd(vfc_pkg::OFF_FPSC, rm | {30'h0, hbad(a1[15:0]), hbad(a0[15:0])});
    end
    for (int i = 0; i < 40; i++) begin
      op = 4'h1 + 4'(i % 4);
      sg = op == vfc_pkg::OP_CFSF || op == vfc_pkg::OP_CFSI;
      rm = rnd() & 32'h600;
      b1 = (i == 1) ? 32'h1 : mk(rnd(), sg);
      b0 = (i < 4) ? 32'h80000000 : mk(rnd(), sg);
      wr(vfc_pkg::OFF_FPSC, rm);
      ops(32'h0, 32'h0, b1, b0);
      wr(vfc_pkg::OFF_CMD, {28'h0, op});
      c = (op == vfc_pkg::OP_CFSF) ? 31 : (op == vfc_pkg::OP_CFUF) ? 32 : 0;
      res_lo = i2f(b0, sg, c);
      rd(vfc_pkg::OFF_RES_HI, i2f(b1, sg, c));
      rd(vfc_pkg::OFF_RES_LO, res_lo);
      rd(vfc_pkg::OFF_FPSC, rm);
    end
    // all-ones word rounds up under nearest and toward +inf only
    for (int r = 0; r < 4; r++) begin
      rm = 32'(r) << 9;
      wr(vfc_pkg::OFF_FPSC, rm);
      ops(32'h0, 32'h0, 32'h1, 32'hFFFFFFFF);
      wr(vfc_pkg::OFF_CMD, {28'h0, vfc_pkg::OP_CFUI});
      res_lo = r[0] ? 32'h4F7FFFFF : 32'h4F800000;
      rd(vfc_pkg::OFF_RES_HI, 32'h3F800000);
      rd(vfc_pkg::OFF_RES_LO, res_lo);
      rd(vfc_pkg::OFF_FPSC, rm | 32'h14);
    end
    wr(vfc_pkg::OFF_FPSC, 32'h0);
    for (int i = 0; i < 48; i++) begin
      op = vfc_pkg::OP_CMPEQ + 4'(i % 3);
      c = rnd();
      k = c[6:4];
      a0 = (i % 8 == 1) ? 32'h7F800000 : rnd();
      a1 = (i % 8 == 0) ? 32'h80000000 : rnd();
      b0 = c[0] ? a0 : rnd();
      b1 = (i % 8 == 0) ? 32'h0 : (i % 8 == 2) ? 32'h1 : c[1] ? a1 : rnd();
      wr(vfc_pkg::OFF_COND, c);
      ops(a1, a0, b1, b0);
      wr(vfc_pkg::OFF_CMD, {25'h0, k, op});
      ch = cmpb(op, a1, b1);
      cl = cmpb(op, a0, b0);
      ex = c;
      ex[31 - 4 * k -: 4] = {ch, cl, ch | cl, ch & cl};
      rd(vfc_pkg::OFF_COND, ex);
      rd(vfc_pkg::OFF_FPSC, {30'h0, bad(a1) | bad(b1), bad(a0) | bad(b0)});
    end
    chk({31'h0, irq}, 32'h0);
    wr(vfc_pkg::OFF_FPSC, 32'h100);
    ops(32'h0, 32'h7F800000, 32'h3C00, 32'h7C00);
    wr(vfc_pkg::OFF_CMD, {28'h0, vfc_pkg::OP_CFH});
    rd(vfc_pkg::OFF_RES_LO, res_lo);
    rd(vfc_pkg::OFF_FPSC, 32'h101);
    wr(vfc_pkg::OFF_COND, 32'h12345678);
    wr(vfc_pkg::OFF_CMD, {25'h0, 3'h2, vfc_pkg::OP_CMPLT});
    rd(vfc_pkg::OFF_COND, 32'h12345678);
    rd(vfc_pkg::OFF_CMD, {25'h0, 3'h2, vfc_pkg::OP_CMPLT});
    chk({31'h0, irq}, 32'h1);
    rd(vfc_pkg::OFF_IRQ_STAT, 32'h3);
    wr(vfc_pkg::OFF_IRQ_STAT, 32'h3);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule : vector_sp_float_convert_compare_bench
